// [gpc_pkg.sv]
// gpc_pkg: constants, offsets and field layouts for the pad/port block.
// assumes: one 40 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package gpc_pkg;
   // port geometry: ports B, D, E, J in that order, eight pins each
   localparam int unsigned NUM_PORTS  = 4;
   localparam int unsigned PORT_W     = 8;
   localparam int unsigned NUM_PINS   = NUM_PORTS * PORT_W;
   localparam int unsigned PORT_B     = 0;
   localparam int unsigned PORT_D     = 1;
   localparam int unsigned PORT_E     = 2;
   localparam int unsigned PORT_J     = 3;
   // register word indices (byte address = index * 4)
   localparam logic [4:0]  IDX_DIR0   = 5'h00;  // port p: 4*p + 0
   localparam logic [4:0]  IDX_LAT0   = 5'h01;  // port p: 4*p + 1
   localparam logic [4:0]  IDX_LVL0   = 5'h02;  // port p: 4*p + 2
   localparam logic [4:0]  IDX_STRIDE = 5'h04;
   localparam logic [4:0]  IDX_PADCFG = 5'h10;
   localparam logic [4:0]  IDX_OD1    = 5'h11;
   localparam logic [4:0]  IDX_OD2    = 5'h12;
   localparam logic [4:0]  IDX_OD3    = 5'h13;
   localparam logic [4:0]  IDX_MISC   = 5'h14;
   // reset values
   localparam logic [31:0] DIR_RST    = 32'hFFFFFFFF;
   localparam logic [31:0] LAT_RST    = 32'h00000000;
   localparam logic [7:0]  REG8_RST   = 8'h00;
   // writable masks of the open-drain control registers
   localparam logic [7:0]  OD1_MASK   = 8'hE1;
   localparam logic [7:0]  OD2_MASK   = 8'hFF;
   localparam logic [7:0]  OD3_MASK   = 8'hC0;
   // misc register bit positions
   localparam int unsigned MISC_BPU   = 0;
   localparam int unsigned MISC_CALOE = 1;
   // open-drain capable peripheral outputs land on pins OD_PIN_BASE + k
   localparam int unsigned NUM_OD     = 14;
   localparam int unsigned OD_PIN_BASE = 8;
   // calendar output select codes
   localparam logic [1:0]  CAL_ALARM  = 2'h0;
   localparam logic [1:0]  CAL_SECOND = 2'h1;
   localparam logic [1:0]  CAL_SOURCE = 2'h2;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // pad configuration register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       d_pu;     // group_d_pullup_enable
      logic       e_pu;     // group_e_pullup_enable
      logic       j_pu;     // group_j_pullup_enable
      logic [1:0] rsv_hi;   // unimplemented, zero
      logic [1:0] cal_sel;  // calendar_output_select
      logic       rsv_lo;   // unimplemented, zero
   } gpc_padcfg_t;
endpackage
`default_nettype wire

// [gpc_gpio_pad_config.sv]
// gpc_gpio_pad_config: port direction/latch/pin-level logic, pull-up groups,
// calendar output select and peripheral open-drain control behind AXI4-Lite.
// assumes: pad_in and small_pkg come from pins; peripheral and calendar
// signals come from logic on sys_clk.
//
// Overview of operation
// - reading a pin-level register returns synchronised pin levels, not latches.
// - writing a pin-level register stores the value into the output latch.
// - direction bit 1 makes the pin an input with its driver off.
// - direction bit 0 drives the pin with its output latch bit.
// - latch register reads and rewrites latch values, whatever the pins show.
// - an enabled peripheral owns its pin; port logic cannot drive it.
// - ports B, D, E, J each have weak pull-ups under one group enable.
// - pull-up enables for D, E, J sit in pad configuration bits 7:5.
// - with group enable 1, each pull-up follows its pin's latch bit.
// - with group enable 0, all pull-ups of that port are off.
// - calendar select 00 alarm, 01 seconds, 10 source clock, 11 reserved.
// - calendar pin shows the selection only while its output enable is set.
// - J pull-up enable is absent on the small package and reads 0.
// - open-drain option exists only on serial, SPI and capture/compare outputs.
// - open-drain bit set gives open-drain drive; cleared gives push-pull.
// - open-drain bits enable at 1, disable at 0, and reset to 0.
`default_nettype none
module gpc_gpio_pad_config
   import gpc_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                reset,
   // AXI4-Lite slave
   input  wire logic [31:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [31:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // pins
   input  wire logic [NUM_PINS-1:0] pad_in,
   output var  logic [NUM_PINS-1:0] pad_out_q,
   output var  logic [NUM_PINS-1:0] pad_oe_q,
   output var  logic [NUM_PINS-1:0] pad_pullup_q,
   input  wire logic                small_pkg,
   // peripherals sharing the pins
   input  wire logic [NUM_PINS-1:0] periph_en,
   input  wire logic [NUM_PINS-1:0] periph_out,
   input  wire logic [NUM_PINS-1:0] periph_oe,
   // clock-calendar sources and pin
   input  wire logic                cal_alarm,
   input  wire logic                cal_seconds,
   input  wire logic                cal_source,
   output var  logic                calendar_pin_q
);

   // control and status storage
   logic [NUM_PINS-1:0] dir_q;
   logic [NUM_PINS-1:0] latch_q;
   gpc_padcfg_t         cfg_q;
   logic [7:0]          od1_q;
   logic [7:0]          od2_q;
   logic [7:0]          od3_q;
   logic                bpu_q;
   logic                caloe_q;
   logic [NUM_PINS-1:0] pin_meta_q;
   logic [NUM_PINS-1:0] pin_sync_q;
   logic                small_meta_q;
   logic                small_q;

   // write channel holding registers
   logic                aw_full_q;
   logic                w_full_q;
   logic [4:0]          widx_q;
   logic [7:0]          wdata_q;
   logic                wlane_q;
   logic                aw_full_d;
   logic                w_full_d;
   logic                do_wr;
   logic                wr_hit;
   logic [4:0]          ridx;
   logic [31:0]         rd_word;
   logic                rd_hit;

   // pad drive next values
   logic [NUM_PINS-1:0] od_pin;
   logic [NUM_PINS-1:0] group_en;
   logic [NUM_PINS-1:0] pad_out_d;
   logic [NUM_PINS-1:0] pad_oe_d;
   logic [NUM_PINS-1:0] pullup_d;
   logic                calendar_d;

   // two-stage synchronisers for the pins and the package strap
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_meta_q   <= '0;
         pin_sync_q   <= '0;
         small_meta_q <= 1'b0;
         small_q      <= 1'b0;
      end else begin
         pin_meta_q   <= pad_in;
         pin_sync_q   <= pin_meta_q;
         small_meta_q <= small_pkg;
         small_q      <= small_meta_q;
      end
   end

   // write address and data are caught independently, then committed together
   assign do_wr     = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign aw_full_d = do_wr ? 1'b0 : (aw_full_q | (s_axi_awvalid & s_axi_awready));
   assign w_full_d  = do_wr ? 1'b0 : (w_full_q | (s_axi_wvalid & s_axi_wready));
   assign wr_hit    = (widx_q[4] == 1'b0) ? (widx_q[1:0] != 2'h3) && ({1'b0, widx_q[3:2]} < 3'(NUM_PORTS))
                    : (widx_q <= IDX_MISC);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         widx_q        <= 5'h00;
         wdata_q       <= 8'h00;
         wlane_q       <= 1'b0;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         s_axi_awready <= ~aw_full_d;
         s_axi_wready  <= ~w_full_d;
         if (s_axi_awvalid && s_axi_awready) begin
            widx_q <= s_axi_awaddr[6:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // port direction and output latch registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dir_q   <= DIR_RST;
         latch_q <= LAT_RST;
      end else if (do_wr && wlane_q && widx_q[4] == 1'b0 && {1'b0, widx_q[3:2]} < 3'(NUM_PORTS)) begin
         unique case (widx_q[1:0])
            IDX_DIR0[1:0]: dir_q[widx_q[3:2]*PORT_W +: PORT_W]   <= wdata_q;
            IDX_LAT0[1:0]: latch_q[widx_q[3:2]*PORT_W +: PORT_W] <= wdata_q;
            IDX_LVL0[1:0]: latch_q[widx_q[3:2]*PORT_W +: PORT_W] <= wdata_q;
            default: ;
         endcase
      end
   end

   // pad configuration, open-drain controls and misc enables
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_q   <= gpc_padcfg_t'(REG8_RST);
         od1_q   <= REG8_RST;
         od2_q   <= REG8_RST;
         od3_q   <= REG8_RST;
         bpu_q   <= 1'b0;
         caloe_q <= 1'b0;
      end else begin
         if (do_wr && wlane_q) begin
            unique case (widx_q)
               IDX_PADCFG: begin
                  cfg_q.d_pu    <= wdata_q[7];
                  cfg_q.e_pu    <= wdata_q[6];
                  cfg_q.j_pu    <= wdata_q[5] & ~small_q;
                  cfg_q.cal_sel <= wdata_q[2:1];
               end
               IDX_OD1: od1_q <= wdata_q & OD1_MASK;
               IDX_OD2: od2_q <= wdata_q & OD2_MASK;
               IDX_OD3: od3_q <= wdata_q & OD3_MASK;
               IDX_MISC: begin
                  bpu_q   <= wdata_q[MISC_BPU];
                  caloe_q <= wdata_q[MISC_CALOE];
               end
               default: ;
            endcase
         end
         if (small_q) begin
            cfg_q.j_pu <= 1'b0;
         end
         cfg_q.rsv_hi <= 2'h0;
         cfg_q.rsv_lo <= 1'b0;
      end
   end

   // read data multiplexer
   assign ridx = s_axi_araddr[6:2];
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      if (ridx[4] == 1'b0 && {1'b0, ridx[3:2]} < 3'(NUM_PORTS) && ridx[1:0] != 2'h3) begin
         unique case (ridx[1:0])
            IDX_DIR0[1:0]: rd_word[7:0] = dir_q[ridx[3:2]*PORT_W +: PORT_W];
            IDX_LAT0[1:0]: rd_word[7:0] = latch_q[ridx[3:2]*PORT_W +: PORT_W];
            default:       rd_word[7:0] = pin_sync_q[ridx[3:2]*PORT_W +: PORT_W];
         endcase
      end else begin
         unique case (ridx)
            IDX_PADCFG: rd_word[7:0] = cfg_q;
            IDX_OD1:    rd_word[7:0] = od1_q;
            IDX_OD2:    rd_word[7:0] = od2_q;
            IDX_OD3:    rd_word[7:0] = od3_q;
            IDX_MISC:   rd_word[1:0] = {caloe_q, bpu_q};
            default:    rd_hit = 1'b0;
         endcase
      end
   end

   // read channel: answer one cycle after the address is taken
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // open-drain capable pins and pull-up group enables per pin
   always_comb begin
      od_pin = '0;
      od_pin[OD_PIN_BASE +: NUM_OD] = {od3_q[7:6], od2_q, od1_q[7:5], od1_q[0]};
      group_en = {{PORT_W{cfg_q.j_pu}}, {PORT_W{cfg_q.e_pu}},
                  {PORT_W{cfg_q.d_pu}}, {PORT_W{bpu_q}}};
   end

   // pin drive: peripheral first, else direction and latch
   always_comb begin
      for (int n = 0; n < NUM_PINS; n++) begin
         if (periph_en[n]) begin
            pad_out_d[n] = od_pin[n] ? 1'b0 : periph_out[n];
            pad_oe_d[n]  = od_pin[n] ? (periph_oe[n] & ~periph_out[n]) : periph_oe[n];
         end else begin
            pad_out_d[n] = latch_q[n];
            pad_oe_d[n]  = ~dir_q[n];
         end
         pullup_d[n] = group_en[n] & latch_q[n];
      end
   end

   // calendar pin source selection
   always_comb begin
      unique case (cfg_q.cal_sel)
         CAL_ALARM:  calendar_d = cal_alarm;
         CAL_SECOND: calendar_d = cal_seconds;
         CAL_SOURCE: calendar_d = cal_source;
         default:    calendar_d = 1'b0; // reserved code drives low
      endcase
      calendar_d = calendar_d & caloe_q;
   end

   // registered pad outputs
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pad_out_q      <= '0;
         pad_oe_q       <= '0;
         pad_pullup_q   <= '0;
         calendar_pin_q <= 1'b0;
      end else begin
         pad_out_q      <= pad_out_d;
         pad_oe_q       <= pad_oe_d;
         pad_pullup_q   <= pullup_d;
         calendar_pin_q <= calendar_d;
      end
   end

   // checks on the block's own behaviour
   a_level_readback: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(s_axi_rvalid) && $past(ridx) == IDX_LVL0 |-> s_axi_rdata[7:0] == $past(pin_sync_q[7:0]))
      else $error("pin-level read does not show pin levels");
   a_level_write: assert property (@(posedge sys_clk) disable iff (reset)
      do_wr && wlane_q && widx_q == IDX_LVL0 |=> latch_q[7:0] == $past(wdata_q))
      else $error("pin-level write missed the latch");
   a_input_hiz: assert property (@(posedge sys_clk) disable iff (reset)
      !periph_en[0] && dir_q[0] |=> !pad_oe_q[0])
      else $error("input pin still driven");
   a_output_drive: assert property (@(posedge sys_clk) disable iff (reset)
      !periph_en[0] && !dir_q[0] |=> pad_oe_q[0] && pad_out_q[0] == $past(latch_q[0]))
      else $error("output pin not driven from latch");
   a_periph_owns: assert property (@(posedge sys_clk) disable iff (reset)
      periph_en[0] |=> pad_out_q[0] == $past(periph_out[0]) && pad_oe_q[0] == $past(periph_oe[0]))
      else $error("peripheral lost its pin");
   a_pullup_group: assert property (@(posedge sys_clk) disable iff (reset)
      1'b1 |=> pad_pullup_q[PORT_D*PORT_W] == $past(cfg_q.d_pu & latch_q[PORT_D*PORT_W]))
      else $error("pull-up not following group and latch");
   a_cal_route: assert property (@(posedge sys_clk) disable iff (reset)
      caloe_q && cfg_q.cal_sel == CAL_SECOND |=> calendar_pin_q == $past(cal_seconds))
      else $error("calendar pin not routed");
   a_cal_gate: assert property (@(posedge sys_clk) disable iff (reset)
      !caloe_q |=> !calendar_pin_q)
      else $error("calendar pin active while disabled");
   a_j_absent: assert property (@(posedge sys_clk) disable iff (reset)
      small_q && $past(small_q) |-> !cfg_q.j_pu)
      else $error("J pull-up enable set on small package");
   a_od_drive: assert property (@(posedge sys_clk) disable iff (reset)
      periph_en[OD_PIN_BASE] && od1_q[0] |=> !pad_out_q[OD_PIN_BASE]
      && pad_oe_q[OD_PIN_BASE] == $past(periph_oe[OD_PIN_BASE] & ~periph_out[OD_PIN_BASE]))
      else $error("open-drain pin drove high");
   a_od_reset: assert property (@(posedge sys_clk)
      reset |=> od1_q == 8'h00 && od2_q == 8'h00 && od3_q == 8'h00)
      else $error("open-drain bits not cleared by reset");
   a_rsv_zero: assert property (@(posedge sys_clk) disable iff (reset)
      $past(do_wr) && !$past(reset) |=> cfg_q.rsv_hi == 2'h0 && !cfg_q.rsv_lo)
      else $error("unimplemented pad bits not zero");

endmodule // gpc_gpio_pad_config
`default_nettype wire

// [gpc_board_model.sv]
// gpc_board_model: board logic on the pins, resolving the level of each wire.
// assumes: the bench drives the board only where the block is off the pin.
`default_nettype none
module gpc_board_model
   import gpc_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic [NUM_PINS-1:0] pad_out_q,
   input  wire logic [NUM_PINS-1:0] pad_oe_q,
   input  wire logic [NUM_PINS-1:0] pad_pullup_q,
   input  wire logic [NUM_PINS-1:0] board_en,
   input  wire logic [NUM_PINS-1:0] board_val,
   output var  logic [NUM_PINS-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NUM_PINS-1:0] float_q = '0;
   // an undriven wire wanders every cycle
   always @(posedge sys_clk) begin
      float_q <= ~float_q;
   end
   // block driver first, then board driver, then weak pull-up
   always_comb begin
      for (int n = 0; n < NUM_PINS; n++) begin
         if (pad_oe_q[n]) pad_in[n] = pad_out_q[n];
         else if (board_en[n]) pad_in[n] = board_val[n];
         else pad_in[n] = pad_pullup_q[n] | float_q[n];
      end
   end
endmodule  // gpc_board_model
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for the pad and port block, with a bench model.
// assumes: gpc_pkg, the block and the board model are compiled first.
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
   import gpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                sys_clk = 1'b0, reset = 1'b1, small_pkg = 1'b0, ce;
   logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, calendar_pin_q;
   logic [31:0]         s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0]          s_axi_wstrb = 4'h1;
   logic [1:0]          s_axi_bresp, s_axi_rresp, sel;
   logic                cal_alarm = 1'b0, cal_seconds = 1'b0, cal_source = 1'b0;
   logic [NUM_PINS-1:0] periph_en = '0, periph_out = '0, periph_oe = '0, board_en = '0, board_val = '0;
   logic [NUM_PINS-1:0] pad_in, pad_out_q, pad_oe_q, pad_pullup_q, e_out, e_oe, e_pu;
   logic [7:0]          m_dir [4], m_lat [4], m_od [3], m_pad, m_misc;
   int                  err_total = 0, checked = 0;

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   gpc_gpio_pad_config DUT (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in,
      .pad_out_q, .pad_oe_q, .pad_pullup_q, .small_pkg, .periph_en, .periph_out, .periph_oe, .cal_alarm,
      .cal_seconds, .cal_source, .calendar_pin_q);
   gpc_board_model BRD (.sys_clk, .pad_out_q, .pad_oe_q, .pad_pullup_q, .board_en, .board_val, .pad_in);

   // address decode of the bench model
   function automatic logic ok(input logic [31:0] a);
      return (a[6:2] < IDX_PADCFG) ? (a[3:2] != 2'h3) : (a[6:2] <= IDX_MISC);
   endfunction
   // bench model of a register read
   function automatic logic [7:0] m_rd(input logic [31:0] a);
      logic [NUM_PINS-1:0] lvl;
      lvl = (e_oe & e_out) | (~e_oe & board_val);
      case (a[6:2])
         IDX_PADCFG: return m_pad;
         IDX_OD1: return m_od[0];
         IDX_OD2: return m_od[1];
         IDX_OD3: return m_od[2];
         IDX_MISC: return m_misc;
         default: ;
      endcase
      if (!ok(a)) return 8'h00;
      if (a[3:2] == 2'h0) return m_dir[a[5:4]];
      if (a[3:2] == 2'h1) return m_lat[a[5:4]];
      return lvl[8*a[5:4] +: 8];
   endfunction
   // bench model of a register write
   function automatic void m_wr(input logic [31:0] a, input logic [7:0] d);
      case (a[6:2])
         IDX_PADCFG: m_pad = d & (small_pkg ? 8'hC6 : 8'hE6);
         IDX_OD1: m_od[0] = d & OD1_MASK;
         IDX_OD2: m_od[1] = d & OD2_MASK;
         IDX_OD3: m_od[2] = d & OD3_MASK;
         IDX_MISC: m_misc = d & 8'h03;
         default: if (ok(a) && a[3:2] == 2'h0) m_dir[a[5:4]] = d; else if (ok(a)) m_lat[a[5:4]] = d;
      endcase
   endfunction
   // expected pin drive, enable and pull-up
   function automatic void m_pins();
      logic [13:0] odv;
      logic [3:0]  gen;
      odv = {m_od[2][7:6], m_od[1], m_od[0][7:5], m_od[0][0]};
      gen = {m_pad[5] & ~small_pkg, m_pad[6], m_pad[7], m_misc[MISC_BPU]};
      for (int n = 0; n < NUM_PINS; n++) begin
         e_pu[n] = gen[n/8] & m_lat[n/8][n%8];
         e_out[n] = periph_en[n] ? periph_out[n] : m_lat[n/8][n%8];
         e_oe[n] = periph_en[n] ? periph_oe[n] : ~m_dir[n/8][n%8];
         if (periph_en[n] && n >= OD_PIN_BASE && n < OD_PIN_BASE + NUM_OD && odv[n - OD_PIN_BASE]) begin
            e_out[n] = 1'b0;
            e_oe[n] = periph_oe[n] & ~periph_out[n];
         end
      end
   endfunction
   // reset contents of the bench model
   function automatic void m_init();
      for (int p = 0; p < 4; p++) begin
         m_dir[p] = DIR_RST[7:0];
         m_lat[p] = LAT_RST[7:0];
      end
      m_od = '{REG8_RST, REG8_RST, REG8_RST};
      m_pad = REG8_RST;
      m_misc = REG8_RST;
   endfunction

   // AXI4-Lite write, address and data offered together
   task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50) err_total++;
      if (s[0]) m_wr(a, d);
      `CHK(s_axi_bresp, ok(a) ? RESP_OKAY : RESP_SLVERR)
   endtask
   // AXI4-Lite read, compared with the bench model
   task automatic axi_rd(input logic [31:0] a);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      if (n >= 50) err_total++;
      `CHK(s_axi_rdata, {24'h0, m_rd(a)})
      `CHK(s_axi_rresp, ok(a) ? RESP_OKAY : RESP_SLVERR)
   endtask
   // settle the wires, then compare every pad output and pin level
   task automatic chk_pins();
      @(posedge sys_clk);
      m_pins();
      board_en <= ~e_oe;
      board_val <= $urandom;
      repeat (5) @(posedge sys_clk);
      `CHK(pad_out_q, e_out)
      `CHK(pad_oe_q, e_oe)
      `CHK(pad_pullup_q, e_pu)
      for (int p = 0; p < 4; p++) axi_rd({26'h0, 2'(p), 4'h8});
   endtask
   task automatic rd_all();
      for (int i = 0; i < 22; i++) axi_rd({25'h0, 5'(i), 2'h0});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      report_and_stop();
   end

   // main sequence
   initial begin
      void'($urandom(32'h58CA));
      m_init();
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      chk_pins();
      rd_all();
      $display("test reset values done");
      repeat (12) axi_wr({26'h0, 2'($urandom), 2'($urandom % 3), 2'h0}, 8'($urandom), 4'h1);
      chk_pins();
      rd_all();
      $display("test port logic done");
      axi_wr(32'h50, 8'hFF, 4'h1);
      axi_wr(32'h40, 8'hFF, 4'h1);
      chk_pins();
      axi_wr(32'h40, 8'h00, 4'h0);
      axi_rd(32'h40);
      small_pkg <= 1'b1;
      m_pad[5] = 1'b0;
      chk_pins();
      axi_wr(32'h40, 8'hBF, 4'h1);
      axi_rd(32'h40);
      $display("test pull-up config done");
      for (int c = 0; c < 8; c++) begin
         axi_wr(32'h50, {6'h0, 1'(c), 1'($urandom)}, 4'h1);
         axi_wr(32'h40, {3'($urandom), 2'h0, 2'(c >> 1), 1'b0}, 4'h1);
         sel = 2'(c >> 1);
         repeat (4) begin
            @(posedge sys_clk);
            {cal_alarm, cal_seconds, cal_source} <= 3'($urandom);
            repeat (2) @(posedge sys_clk);
            ce = (sel == CAL_ALARM) ? cal_alarm : (sel == CAL_SECOND) ? cal_seconds : (sel == CAL_SOURCE) & cal_source;
            `CHK(calendar_pin_q, m_misc[MISC_CALOE] & ce)
         end
      end
      chk_pins();
      $display("test calendar pin done");
      repeat (6) begin
         for (int k = 0; k < 3; k++) axi_wr(32'h44 + 32'(4 * k), 8'($urandom), 4'h1);
         periph_en <= $urandom;
         periph_out <= $urandom;
         periph_oe <= $urandom;
         chk_pins();
      end
      rd_all();
      $display("test open-drain done");
      axi_wr(32'h0C, 8'h5A, 4'h1);
      reset <= 1'b1;
      m_init();
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      chk_pins();
      rd_all();
      $display("test second reset done");
      report_and_stop();
   end
endmodule  // tb_top
`default_nettype wire
